// ---- hdl/sop_pkg.sv ----
// ***************************************************************
// constants and types of the sum-of-products macrocell array
// ***************************************************************
package sop_pkg;
    // array geometry
    localparam int NUM_IN = 12; // dedicated inputs
    localparam int NUM_MC = 10; // macrocells
    localparam int NUM_SIG = NUM_IN + NUM_MC; // signals into the and array
    localparam int COLS = 2 * NUM_SIG; // true and complement columns
    localparam int TERMS = 132; // all product terms
    localparam int TERM_PAD = TERMS + 16; // padded term vector width
    localparam int MAX_SUM = 16; // widest or gate
    localparam int RESET_TERM_IDX = 0; // async reset term index
    localparam int PRESET_TERM_IDX = 131; // sync preset term index
    // per macrocell: output enable term, its sum terms follow it
    localparam int OE_IDX [NUM_MC] = '{1, 10, 21, 34, 49, 66, 83, 98, 111, 122};
    // per macrocell: which of the 16 slots are wired into the or
    localparam logic [15:0] SUM_MASK [NUM_MC] = '{
        16'h00ff, 16'h03ff, 16'h0fff, 16'h3fff, 16'hffff,
        16'hffff, 16'h3fff, 16'h0fff, 16'h03ff, 16'h00ff};
    // apb map
    localparam int ADDR_W = 12; // byte address width
    localparam logic [11:0] POLARITY_ADDR = 12'h800; // polarity select bits
    localparam logic [11:0] BYPASS_ADDR = 12'h804; // register bypass bits
    localparam logic [11:0] SECURITY_ADDR = 12'h808; // security fuse, set only
    localparam logic [11:0] PRELOAD_ADDR = 12'h80c; // write bit 0 to preload
    localparam logic [11:0] STATE_ADDR = 12'h810; // flop state and enables
    localparam int FUSE_WIN_BIT = 11; // zero selects the fuse window
    localparam int FUSE_HI_W = COLS - 32; // width of a term's upper word
    localparam int OE_FIELD = 16; // enable field position in state word
    // power-up hold
    localparam int CLK_NS = 20; // mclk period
    localparam int POWERUP_NS = 1000; // longest power-up reset time
    localparam logic [5:0] PUP_CYCLES = 6'(POWERUP_NS / CLK_NS); // rounds down
    // macrocell configuration
    typedef struct packed {
        logic [NUM_MC-1:0] polarity; // polarity_select_bit per cell
        logic [NUM_MC-1:0] bypass; // register_bypass_bit per cell
    } mc_cfg_t;
    // whole state of the block
    typedef struct packed {
        logic [NUM_IN-1:0] inSync1; // first input stage
        logic [NUM_IN-1:0] inSync2; // second input stage
        logic [NUM_MC-1:0] ioSync1; // first pin stage
        logic [NUM_MC-1:0] ioSync2; // second pin stage
        logic [NUM_MC-1:0] q; // macrocell flops
        logic [TERMS-1:0][COLS-1:0] fuse; // one means link opened
        mc_cfg_t cfg; // configuration bits
        logic secure; // security fuse
        logic [NUM_MC-1:0] pinOut; // pin output levels
        logic [NUM_MC-1:0] pinOe; // pin drive enables
        logic [31:0] prdata; // apb read data
        logic pready; // apb ready
        logic pslverr; // apb error
        logic [5:0] pupCount; // power-up cycles left
    } state_t;
    localparam state_t STATE_RESET = '{pupCount: PUP_CYCLES, default: '0};
endpackage

// ---- hdl/sop_macrocell_array.sv ----
// Operation
// - fully opened term evaluates high
// - term with input and complement is low
// - twelve inputs, ten macrocells driving pins
// - eight to sixteen terms per output
// - macrocell takes or of its terms
// - config bits default zero, one when programmed
// - true and complement of every input
// - flop captures sum each rising edge
// - bypass zero: registered, feedback inverted flop
// - bypass one: combinatorial, feedback from pin
// - output enable is its own term
// - disabled combinatorial cell acts as input
// - polarity bit applies in both modes
// - preset and reset act on all cells
// - preset loads ones next edge
// - reset clears flops without waiting
// - preset and reset touch only flop state
// - flops cleared at power-up within 1000 ns
// - registers preloadable from pins
// - security: readback all ones, no preload
`timescale 1ns/1ps
`default_nettype none

module sop_macrocell_array (
    input wire logic mclk, // 50 MHz clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic [11:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [11:0] dedIn, // dedicated input pins
    input wire logic [9:0] ioIn, // i/o pin levels seen
    output logic [9:0] ioOut, // i/o pin drive levels
    output logic [9:0] ioOe // i/o pin drive enables
);

    // ***************************************************************
    // state and array signals
    // ***************************************************************
    sop_pkg::state_t st_reg; // registered state
    sop_pkg::state_t st_next; // next state
    logic [sop_pkg::COLS-1:0] colVec; // and array columns
    logic [sop_pkg::TERM_PAD-1:0] termVec; // evaluated product terms
    logic [sop_pkg::NUM_MC-1:0] sumVec; // or array outputs
    logic [sop_pkg::NUM_MC-1:0] oeVec; // enable terms per cell
    logic [sop_pkg::NUM_MC-1:0] qEff; // flop state after async clear
    logic [sop_pkg::NUM_MC-1:0] cellVal; // value before polarity
    logic asyncResetTerm; // async_reset_term
    logic syncPresetTerm; // sync_preset_term
    logic pupBusy; // power-up hold active
    logic access; // apb access phase
    logic fuseHit; // address inside fuse window
    logic [7:0] termIdx; // term addressed
    logic preloadReq; // preload strobe this cycle

    // ***************************************************************
    // input columns
    // ***************************************************************
    // true and complement of each synchronised input
    genvar gi;
    generate
        for (gi = 0; gi < sop_pkg::NUM_IN; gi++)
        begin : g_in
            assign colVec[2*gi] = st_reg.inSync2[gi];
            assign colVec[2*gi+1] = ~st_reg.inSync2[gi];
        end
    endgenerate

    // async clear seen at once by feedback and sums
    assign qEff = asyncResetTerm ? '0 : st_reg.q;

    // feedback columns chosen by bypass bit
    generate
        for (gi = 0; gi < sop_pkg::NUM_MC; gi++)
        begin : g_fb
            localparam int C = 2 * (sop_pkg::NUM_IN + gi); // column pair base
            // registered: inverted flop; combinatorial: the pin
            assign colVec[C] = st_reg.cfg.bypass[gi] ? st_reg.ioSync2[gi]
                                                     : ~qEff[gi];
            assign colVec[C+1] = ~colVec[C];
        end
    endgenerate

    // ***************************************************************
    // and array
    // ***************************************************************
    // an opened link forces its column to one; all open gives high
    genvar gt;
    generate
        for (gt = 0; gt < sop_pkg::TERM_PAD; gt++)
        begin : g_term
            if (gt < sop_pkg::TERMS)
            begin : g_live
                // both polarities intact drive the and low
                assign termVec[gt] = &(colVec | st_reg.fuse[gt]);
            end
            else
            begin : g_pad
                assign termVec[gt] = 1'b0; // padding, never summed
            end
        end
    endgenerate

    assign asyncResetTerm = termVec[sop_pkg::RESET_TERM_IDX];
    assign syncPresetTerm = termVec[sop_pkg::PRESET_TERM_IDX];

    // ***************************************************************
    // or array
    // ***************************************************************
    // each cell sums its fixed slice of terms
    generate
        for (gi = 0; gi < sop_pkg::NUM_MC; gi++)
        begin : g_or
            localparam int B = sop_pkg::OE_IDX[gi]; // enable term index
            assign oeVec[gi] = termVec[B];
            assign sumVec[gi] = |(termVec[B+1 +: sop_pkg::MAX_SUM]
                                  & sop_pkg::SUM_MASK[gi]);
            // flop path or bypass path
            assign cellVal[gi] = st_reg.cfg.bypass[gi] ? sumVec[gi]
                                                       : qEff[gi];
        end
    endgenerate

    assign pupBusy = (st_reg.pupCount != 6'h00);
    assign access = psel & penable;
    assign fuseHit = !paddr[sop_pkg::FUSE_WIN_BIT]
                     && (paddr[10:3] < 8'(sop_pkg::TERMS));
    assign termIdx = paddr[10:3];
    assign preloadReq = access && st_reg.pready && pwrite
                        && (paddr == sop_pkg::PRELOAD_ADDR) && pwdata[0];

    // ***************************************************************
    // next state
    // ***************************************************************
    always_comb
    begin
        st_next = st_reg;
        // two-stage synchronisers on pins
        st_next.inSync1 = dedIn;
        st_next.inSync2 = st_reg.inSync1;
        st_next.ioSync1 = ioIn;
        st_next.ioSync2 = st_reg.ioSync1;
        // power-up hold countdown
        if (pupBusy)
        begin
            st_next.pupCount = st_reg.pupCount - 6'h01;
        end
        // flops: reset over hold over preload over preset over sum
        if (asyncResetTerm)
        begin
            st_next.q = '0;
        end
        else if (pupBusy)
        begin
            st_next.q = '0;
        end
        else if (preloadReq && !st_reg.secure)
        begin
            st_next.q = st_reg.ioSync2;
        end
        else if (syncPresetTerm)
        begin
            st_next.q = '1;
        end
        else
        begin
            st_next.q = sumVec;
        end
        // pins: polarity applied after the flop, both modes
        // polarity one: pin follows cell; zero: pin inverted
        st_next.pinOut = st_reg.cfg.polarity ~^ cellVal;
        st_next.pinOe = pupBusy ? '0 : oeVec;
        // apb: one wait state, answer on the second access cycle
        st_next.pready = access && !st_reg.pready;
        if (access && !st_reg.pready)
        begin
            st_next.prdata = 32'h0000_0000;
            st_next.pslverr = 1'b0;
            if (fuseHit)
            begin
                // secured array reads as every link opened
                if (st_reg.secure)
                begin
                    st_next.prdata = paddr[2] ? 32'h0000_0fff : 32'hffff_ffff;
                end
                else if (paddr[2])
                begin
                    st_next.prdata = {20'h00000,
                                      st_reg.fuse[termIdx][sop_pkg::COLS-1:32]};
                end
                else
                begin
                    st_next.prdata = st_reg.fuse[termIdx][31:0];
                end
            end
            else
            begin
                case (paddr)
                    sop_pkg::POLARITY_ADDR: st_next.prdata = {22'h000000,
                                                              st_reg.cfg.polarity};
                    sop_pkg::BYPASS_ADDR: st_next.prdata = {22'h000000, st_reg.cfg.bypass};
                    sop_pkg::SECURITY_ADDR: st_next.prdata = {31'h00000000, st_reg.secure};
                    sop_pkg::PRELOAD_ADDR: st_next.prdata = 32'h0000_0000;
                    sop_pkg::STATE_ADDR: st_next.prdata = {6'h00, st_reg.pinOe,
                                                           6'h00, st_reg.q};
                    default: st_next.pslverr = 1'b1; // unmapped address
                endcase
            end
        end
        // writes take effect at the completing edge
        if (access && st_reg.pready && pwrite)
        begin
            if (fuseHit)
            begin
                if (paddr[2])
                begin
                    st_next.fuse[termIdx][sop_pkg::COLS-1:32] =
                        pwdata[sop_pkg::FUSE_HI_W-1:0];
                end
                else
                begin
                    st_next.fuse[termIdx][31:0] = pwdata;
                end
            end
            else
            begin
                case (paddr)
                    sop_pkg::POLARITY_ADDR: st_next.cfg.polarity = pwdata[9:0];
                    sop_pkg::BYPASS_ADDR: st_next.cfg.bypass = pwdata[9:0];
                    sop_pkg::SECURITY_ADDR: st_next.secure = st_reg.secure | pwdata[0];
                    default: st_next.secure = st_reg.secure; // others have no store
                endcase
            end
        end
    end

    // ***************************************************************
    // state register
    // ***************************************************************
    // reset clears flops and config, starts power-up hold
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            st_reg <= sop_pkg::STATE_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign ioOut = st_reg.pinOut;
    assign ioOe = st_reg.pinOe;

    // ***************************************************************
    // assertions
    // ***************************************************************
    property p_term_open;
        @(posedge mclk) disable iff (!resetn)
        (st_reg.fuse[sop_pkg::PRESET_TERM_IDX] == '1) |-> syncPresetTerm;
    endproperty
    a_term_open: assert property (p_term_open)
        else $error("fully opened term not high");

    property p_term_clash;
        @(posedge mclk) disable iff (!resetn)
        (st_reg.fuse[7][1:0] == 2'b00) |-> !termVec[7];
    endproperty
    a_term_clash: assert property (p_term_clash)
        else $error("term with input and complement not low");

    property p_reset_wins;
        @(posedge mclk) disable iff (!resetn)
        (asyncResetTerm && syncPresetTerm) |=> (st_reg.q == '0);
    endproperty
    a_reset_wins: assert property (p_reset_wins)
        else $error("preset beat reset");

    property p_reset_now;
        @(posedge mclk) disable iff (!resetn)
        asyncResetTerm |-> (qEff == '0) ##1 (st_reg.q == '0);
    endproperty
    a_reset_now: assert property (p_reset_now)
        else $error("async reset did not clear flops");

    property p_preset;
        @(posedge mclk) disable iff (!resetn)
        (syncPresetTerm && !asyncResetTerm && !pupBusy && !preloadReq)
            |=> (st_reg.q == '1);
    endproperty
    a_preset: assert property (p_preset)
        else $error("preset did not load ones");

    property p_capture;
        @(posedge mclk) disable iff (!resetn)
        (!syncPresetTerm && !asyncResetTerm && !pupBusy && !preloadReq)
            |=> (st_reg.q == $past(sumVec));
    endproperty
    a_capture: assert property (p_capture)
        else $error("flops did not capture sums");

    // sampled resetn keeps the edge that releases reset out of it
    property p_polarity;
        @(posedge mclk) disable iff (!resetn)
        resetn |=> (ioOut == (($past(st_reg.cfg.polarity) & $past(cellVal))
                              | (~$past(st_reg.cfg.polarity) & ~$past(cellVal))));
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("pin level ignores polarity");

    property p_enable;
        @(posedge mclk) disable iff (!resetn)
        !pupBusy |=> (ioOe == $past(oeVec));
    endproperty
    a_enable: assert property (p_enable)
        else $error("pin enable does not follow its term");

    property p_pin_feedback;
        @(posedge mclk) disable iff (!resetn)
        st_reg.cfg.bypass[0] |-> (colVec[24] == st_reg.ioSync2[0]);
    endproperty
    a_pin_feedback: assert property (p_pin_feedback)
        else $error("combinatorial feedback not from pin");

    property p_secure_read;
        @(posedge mclk) disable iff (!resetn)
        (access && !st_reg.pready && fuseHit && !paddr[2] && st_reg.secure)
            |=> (pready && prdata == 32'hffff_ffff);
    endproperty
    a_secure_read: assert property (p_secure_read)
        else $error("secured fuse read not all ones");

    property p_powerup;
        @(posedge mclk) disable iff (!resetn)
        $rose(resetn) |-> (st_reg.q == '0) [*8];
    endproperty
    a_powerup: assert property (p_powerup)
        else $error("flops not held low after power-up");

    property p_hold_enable;
        @(posedge mclk) disable iff (!resetn)
        pupBusy |=> ((ioOe == '0) && (st_reg.q == '0));
    endproperty
    a_hold_enable: assert property (p_hold_enable)
        else $error("pins or flops active during power-up hold");

    property p_preload;
        @(posedge mclk) disable iff (!resetn)
        (preloadReq && !st_reg.secure && !asyncResetTerm && !pupBusy)
            |=> (st_reg.q == $past(st_reg.ioSync2));
    endproperty
    a_preload: assert property (p_preload)
        else $error("preload did not load pin levels");

    property p_preload_locked;
        @(posedge mclk) disable iff (!resetn)
        (preloadReq && st_reg.secure && !asyncResetTerm && !pupBusy && !syncPresetTerm)
            |=> (st_reg.q == $past(sumVec));
    endproperty
    a_preload_locked: assert property (p_preload_locked)
        else $error("secured array accepted a preload");

    property p_flop_feedback;
        @(posedge mclk) disable iff (!resetn)
        !st_reg.cfg.bypass[2] |-> (colVec[28] == ~qEff[2]);
    endproperty
    a_flop_feedback: assert property (p_flop_feedback)
        else $error("registered feedback not the inverted flop");

endmodule // sop_macrocell_array

`default_nettype wire

// ---- tb/board_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// board around the array: resolves each i/o pin
// ***************************************************************
module board_model (
    input wire logic [9:0] ioOut, // array drive levels
    input wire logic [9:0] ioOe, // array drive enables
    input wire logic [9:0] boardLevel, // board level on undriven pins
    output logic [9:0] ioIn // resolved pin levels
);
    // array wins where it drives, the board elsewhere
    always_comb
    begin
        for (int i = 0; i < 10; i++)
        begin
            ioIn[i] = ioOe[i] ? ioOut[i] : boardLevel[i];
        end
    end
endmodule // board_model

`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// self-checking bench for the macrocell array
// ***************************************************************
module tb_top;
    logic mclk; // 50 MHz clock
    logic resetn; // sync reset, active low
    logic [11:0] paddr; // apb address
    logic psel; // apb select
    logic penable; // apb access phase
    logic pwrite; // apb direction
    logic [31:0] pwdata; // apb write data
    logic [31:0] prdata; // apb read data
    logic pready; // apb ready
    logic pslverr; // apb error
    logic [11:0] dedIn; // dedicated inputs
    logic [9:0] ioIn; // resolved pins
    logic [9:0] ioOut; // pin drive levels
    logic [9:0] ioOe; // pin drive enables
    logic [9:0] boardLevel; // board level on idle pins
    int miscompares; // mismatches seen
    int checksDone; // comparisons made
    logic [31:0] rdv; // scratch read data
    logic errv; // scratch error flag
    localparam logic [31:0] W0 [3] = '{32'hffff_fffe, 32'hffff_fffd, 32'hffff_fffc};

    sop_macrocell_array sop_macrocell_array_inst (
        .mclk(mclk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dedIn(dedIn), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe)
    );

    board_model board_model_inst (
        .ioOut(ioOut), .ioOe(ioOe), .boardLevel(boardLevel), .ioIn(ioIn)
    );

    // free-running clock
    always #10 mclk = ~mclk;

    // ***************************************************************
    // helpers
    // ***************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checksDone++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge mclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(32'(n < 16), 32'h1, "apb answer");
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, rdv, errv);
        chk(32'(errv), 32'h0, "write error");
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0, rdv, errv);
        chk(rdv, exp, "read data");
    endtask

    // both words of one product term
    task automatic term(input int t, input logic [31:0] w0, input logic [31:0] w1);
        wr(12'(t * 8), w0);
        wr(12'(t * 8 + 4), w1);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ***************************************************************
    // watchdog
    // ***************************************************************
    initial
    begin
        repeat (6000) @(posedge mclk);
        miscompares++;
        results();
    end

    // ***************************************************************
    // tests
    // ***************************************************************
    initial
    begin
        mclk = 1'b0;
        resetn = 1'b0;
        paddr = 12'h000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        dedIn = 12'h000;
        boardLevel = 10'h000;
        miscompares = 0;
        checksDone = 0;
        waitc(8);
        resetn <= 1'b1;
        waitc(60);
        chk(32'(ioOut), 32'h3ff, "powerup pins");
        chk(32'(ioOe), 32'h0, "powerup enables");
        rdc(sop_pkg::POLARITY_ADDR, 32'h0);
        rdc(sop_pkg::BYPASS_ADDR, 32'h0);
        rdc(sop_pkg::STATE_ADDR, 32'h0);
        apb(12'hffc, 1'b0, 32'h0, rdv, errv);
        chk(32'(errv), 32'h1, "unmapped error");
        chk(rdv, 32'h0, "unmapped data");
        $display("test reset done");
        // preset, then reset on top of it
        term(sop_pkg::PRESET_TERM_IDX, 32'hffff_ffff, 32'h0000_0fff);
        waitc(4);
        rdc(sop_pkg::STATE_ADDR, 32'h3ff);
        chk(32'(ioOut), 32'h0, "preset pins");
        term(sop_pkg::RESET_TERM_IDX, 32'hffff_ffff, 32'h0000_0fff);
        rdc(sop_pkg::STATE_ADDR, 32'h0);
        waitc(2);
        chk(32'(ioOut), 32'h3ff, "reset pins");
        term(sop_pkg::PRESET_TERM_IDX, 32'h0, 32'h0);
        term(sop_pkg::RESET_TERM_IDX, 32'h0, 32'h0);
        $display("test preset reset done");
        // enable term fully opened drives pin 0
        term(sop_pkg::OE_IDX[0], 32'hffff_ffff, 32'h0000_0fff);
        waitc(3);
        chk(32'(ioOe), 32'h1, "enable term");
        // combinatorial cell 0: true, complement, both
        wr(sop_pkg::BYPASS_ADDR, 32'h1);
        wr(sop_pkg::POLARITY_ADDR, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            term(2, W0[i], 32'h0000_0fff);
            for (int v = 0; v < 2; v++)
            begin
                dedIn[0] <= v[0];
                waitc(4);
                chk(32'(ioOut[0]), (i == 0) ? 32'(v) : ((i == 1) ? 32'(1 - v) : 32'h0),
                    "comb cell");
            end
        end
        wr(sop_pkg::POLARITY_ADDR, 32'h0);
        waitc(4);
        chk(32'(ioOut[0]), 32'h1, "comb low polarity");
        $display("test comb done");
        // registered cell 1 follows dedIn[1] through its flop
        wr(sop_pkg::POLARITY_ADDR, 32'h2);
        term(11, 32'hffff_fffb, 32'h0000_0fff);
        for (int v = 0; v < 2; v++)
        begin
            dedIn[1] <= v[0];
            waitc(5);
            chk(32'(ioOut[1]), 32'(v), "registered pin");
            rdc(sop_pkg::STATE_ADDR, 32'h10000 | 32'(v * 2));
        end
        $display("test registered done");
        // cell 2 holds itself through inverted flop feedback; preload sets it
        term(22, 32'hdfff_ffff, 32'h0000_0fff);
        boardLevel <= 10'h004;
        waitc(4);
        wr(sop_pkg::PRELOAD_ADDR, 32'h1);
        rdc(sop_pkg::STATE_ADDR, 32'h10006);
        boardLevel <= 10'h000;
        waitc(4);
        wr(sop_pkg::PRELOAD_ADDR, 32'h1);
        rdc(sop_pkg::STATE_ADDR, 32'h10002);
        $display("test preload done");
        // undriven cell 3 pin used as an input by cell 4
        wr(sop_pkg::BYPASS_ADDR, 32'h19);
        wr(sop_pkg::POLARITY_ADDR, 32'h12);
        term(50, 32'hbfff_ffff, 32'h0000_0fff);
        for (int v = 0; v < 2; v++)
        begin
            boardLevel[3] <= v[0];
            waitc(5);
            chk(32'(ioOut[4]), 32'(v), "pin as input");
        end
        $display("test pin input done");
        // security: fuses read as all ones, preload ignored
        wr(sop_pkg::SECURITY_ADDR, 32'h1);
        rdc(sop_pkg::SECURITY_ADDR, 32'h1);
        rdc(12'h320, 32'hffff_ffff);
        boardLevel <= 10'h004;
        waitc(5);
        wr(sop_pkg::PRELOAD_ADDR, 32'h1);
        rdc(sop_pkg::STATE_ADDR, 32'h10002);
        $display("test security done");
        results();
    end
endmodule // tb_top

`default_nettype wire
